// [src/data_ram_256.sv]
// Internal data RAM with one write port and two asynchronous read ports.
`timescale 1ns/1ps
module data_ram_256 (
   input  wire logic       clk_sys,
   input  wire logic       writeEn,
   input  wire logic [7:0] writeAddr,
   input  wire logic [7:0] writeData,
   input  wire logic [7:0] readAddrA,
   output logic      [7:0] readDataA,
   input  wire logic [7:0] readAddrB,
   output logic      [7:0] readDataB
);
   logic [7:0] mem [0:255];

   // Port B serves the index pointer so an indirect access costs one cycle.
   assign readDataA = mem[readAddrA];
   assign readDataB = mem[readAddrB];

   always_ff @(posedge clk_sys) begin
      if (writeEn) begin
         mem[writeAddr] <= writeData;
      end
   end
endmodule

// [src/memory_space_decoder.sv]
// Memory space decoder: routes core accesses to data RAM, SFRs and program memory.
`timescale 1ns/1ps
`include "memory_space_defines.svh"
module memory_space_decoder #(
   parameter int FLASH_BYTES = `FLASH_BYTES_LARGE
) (
   input  wire logic                            clk_sys,
   input  wire logic                            nrst,
   input  wire logic                            reqValid,
   input  wire memory_space_pkg::access_kind_type reqKind,
   input  wire logic [15:0]                     reqAddr,
   input  wire logic                            reqWrite,
   input  wire logic [7:0]                      reqWdata,
   input  wire logic                            reqBitData,
   output logic                                 ready,
   output logic                                 rspValid,
   output logic      [7:0]                      rspData,
   output logic                                 rspBit,
   output logic                                 sfrSel,
   output logic                                 sfrWrite,
   output logic      [7:0]                      sfrAddr,
   output logic      [7:0]                      sfrWdata,
   input  wire logic [7:0]                      sfrRdata,
   output logic      [7:0]                      stack_top_pointer,
   output logic      [1:0]                      bankSelect,
   output logic                                 program_store_write_enable
);
   localparam int FLASH_AW = $clog2(FLASH_BYTES);
   localparam logic [16:0] FLASH_END = 17'(FLASH_BYTES);
   localparam logic HAS_RESV = (FLASH_BYTES == `FLASH_BYTES_LARGE);
   generate
      if (FLASH_BYTES != `FLASH_BYTES_LARGE && FLASH_BYTES != `FLASH_BYTES_MID &&
          FLASH_BYTES != `FLASH_BYTES_SMALL) begin : g_bad_size
         $error("FLASH_BYTES must be 2048, 4096 or 8192");
      end
   endgenerate

   // ***********************************************************
   // Reset release
   // ***********************************************************
   logic [1:0] rstPipe_r;
   logic       rstN;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rstPipe_r <= 2'b00;
      end else begin
         rstPipe_r <= {rstPipe_r[0], 1'b1};
      end
   end
   assign rstN = rstPipe_r[1];

   // ***********************************************************
   // Bit address decode
   // ***********************************************************
   // Low bit space lives in RAM bytes 0x20-0x2F, high space in SFR rows.
   function automatic logic [7:0] bit_byte(input logic [7:0] bitAddr);
      if (bitAddr[7]) begin
         bit_byte = {bitAddr[7:3], 3'b000};
      end else begin
         bit_byte = `BIT_BYTE_BASE + {4'h0, bitAddr[6:3]};
      end
   endfunction

   // ***********************************************************
   // Request decode
   // ***********************************************************
   logic [7:0]                statusWord_r;
   logic [7:0]                stackPtr_r;
   logic                      storeWe_r;
   memory_space_pkg::decode_state_type state_r;
   logic [7:0]                heldAddr_r;
   logic [7:0]                heldByte_r;
   logic [7:0]                ptrAddr;
   logic [7:0]                ptrData;
   logic [7:0]                ramData;
   logic [7:0]                byteAddr;
   logic                      isSfr;
   logic                      isBit;
   logic                      isWr;
   logic                      dataKind;
   logic                      take;
   logic                      hitStack;
   logic                      hitStatus;
   logic                      hitStoreCtl;
   logic                      extSfr;
   logic [7:0]                curByte;
   logic [7:0]                wrByte;
   logic                      ramWe;
   logic                      needWb;
   logic                      progInRange;
   logic                      progWe;
   logic [7:0]                progData;
   assign bankSelect = statusWord_r[`BANK_HI_POS:`BANK_LO_POS];
   // Pointer register is entry 0 or 1 of the active bank.
   assign ptrAddr = {3'b000, bankSelect, 2'b00, reqAddr[0]};
   always_comb begin
      byteAddr = reqAddr[7:0];
      isSfr    = 1'b0;
      isBit    = 1'b0;
      isWr     = reqWrite;
      dataKind = 1'b1;
      case (reqKind)
         memory_space_pkg::KIND_DIRECT: begin
            isSfr = reqAddr[7];
         end
         memory_space_pkg::KIND_INDIRECT: begin
            byteAddr = ptrData;
         end
         memory_space_pkg::KIND_REGISTER: begin
            byteAddr = {3'b000, bankSelect, reqAddr[2:0]};
         end
         memory_space_pkg::KIND_BIT: begin
            isBit    = 1'b1;
            byteAddr = bit_byte(reqAddr[7:0]);
            isSfr    = reqAddr[7];
         end
         memory_space_pkg::KIND_PUSH: begin
            byteAddr = stackPtr_r + 8'h01;
            isWr     = 1'b1;
         end
         memory_space_pkg::KIND_POP: begin
            byteAddr = stackPtr_r;
            isWr     = 1'b0;
         end
         default: begin
            dataKind = 1'b0;
            isWr     = 1'b0;
         end
      endcase
   end
   assign hitStack    = isSfr && (byteAddr == `STACK_PTR_ADDR);
   assign hitStatus   = isSfr && (byteAddr == `STATUS_WORD_ADDR);
   assign hitStoreCtl = isSfr && (byteAddr == `STORE_CTL_ADDR);
   // Reserved SFR addresses are passed outward untouched; their answer is not ours.
   assign extSfr      = isSfr && !hitStack && !hitStatus && !hitStoreCtl;
   always_comb begin
      if (hitStack) begin
         curByte = stackPtr_r;
      end else if (hitStatus) begin
         curByte = statusWord_r;
      end else if (hitStoreCtl) begin
         curByte = {7'h00, storeWe_r};
      end else if (isSfr) begin
         curByte = sfrRdata;
      end else begin
         curByte = ramData;
      end
   end

   // A bit write is a read-modify-write of the byte that holds it.
   always_comb begin
      wrByte = reqWdata;
      if (isBit) begin
         wrByte = curByte;
         wrByte[reqAddr[2:0]] = reqBitData;
      end
   end
   assign ready  = (state_r == memory_space_pkg::ST_IDLE);
   assign take   = reqValid && ready;
   assign ramWe  = take && dataKind && !isSfr && isWr;
   // External SFR bit writes need a second cycle: the peripheral sees a read, then the merged write.
   assign needWb = take && dataKind && extSfr && isWr && isBit;

   // ***********************************************************
   // External SFR port
   // ***********************************************************
   always_comb begin
      if (state_r == memory_space_pkg::ST_WRBACK) begin
         sfrSel   = 1'b1;
         sfrWrite = 1'b1;
         sfrAddr  = heldAddr_r;
         sfrWdata = heldByte_r;
      end else begin
         sfrSel   = take && dataKind && extSfr;
         sfrWrite = take && dataKind && extSfr && isWr && !isBit;
         sfrAddr  = byteAddr;
         sfrWdata = reqWdata;
      end
   end

   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         state_r    <= memory_space_pkg::ST_IDLE;
         heldAddr_r <= 8'h00;
         heldByte_r <= 8'h00;
      end else if (needWb) begin
         state_r    <= memory_space_pkg::ST_WRBACK;
         heldAddr_r <= byteAddr;
         heldByte_r <= wrByte;
      end else begin
         state_r    <= memory_space_pkg::ST_IDLE;
      end
   end

   // ***********************************************************
   // Core registers held here
   // ***********************************************************
   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         stackPtr_r <= `STACK_PTR_RESET;
      end else if (take && reqKind == memory_space_pkg::KIND_PUSH) begin
         stackPtr_r <= stackPtr_r + 8'h01;
      end else if (take && reqKind == memory_space_pkg::KIND_POP) begin
         stackPtr_r <= stackPtr_r - 8'h01;
      end else if (take && dataKind && hitStack && isWr) begin
         stackPtr_r <= wrByte;
      end
   end
   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         statusWord_r <= `STATUS_WORD_RESET;
      end else if (take && dataKind && hitStatus && isWr) begin
         statusWord_r <= wrByte;
      end
   end
   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         storeWe_r <= `STORE_CTL_RESET;
      end else if (take && dataKind && hitStoreCtl && isWr) begin
         storeWe_r <= wrByte[`STORE_WE_POS];
      end
   end

   assign stack_top_pointer          = stackPtr_r;
   assign program_store_write_enable = storeWe_r;

   // ***********************************************************
   // Program space
   // ***********************************************************
   assign progInRange = ({1'b0, reqAddr} < FLASH_END) &&
                        !(HAS_RESV && ({1'b0, reqAddr} >= `FLASH_RESV_START));
   assign progWe = take && (reqKind == memory_space_pkg::KIND_XMOVE) && reqWrite &&
                   storeWe_r && progInRange;
   program_store #(
      .DEPTH (FLASH_BYTES)
   ) u_prog (
      .clk_sys   (clk_sys),
      .writeEn   (progWe),
      .addr      (reqAddr[FLASH_AW-1:0]),
      .writeData (reqWdata),
      .readData  (progData)
   );
   data_ram_256 u_ram (
      .clk_sys   (clk_sys),
      .writeEn   (ramWe),
      .writeAddr (byteAddr),
      .writeData (wrByte),
      .readAddrA (byteAddr),
      .readDataA (ramData),
      .readAddrB (ptrAddr),
      .readDataB (ptrData)
   );

   // ***********************************************************
   // Answer
   // ***********************************************************
   always_ff @(posedge clk_sys or negedge rstN) begin
      if (!rstN) begin
         rspValid <= 1'b0;
         rspData  <= 8'h00;
         rspBit   <= 1'b0;
      end else begin
         rspValid <= (take && !needWb) || (state_r == memory_space_pkg::ST_WRBACK);
         if (take) begin
            if (reqKind == memory_space_pkg::KIND_CODE) begin
               rspData <= progInRange ? progData : `RESERVED_READ;
            end else if (dataKind) begin
               rspData <= curByte;
            end else begin
               rspData <= `RESERVED_READ;
            end
            rspBit <= curByte[reqAddr[2:0]];
         end
      end
   end

   // ***********************************************************
   // Checks
   // ***********************************************************
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstN);
   sequence seqPushTaken;
      take && reqKind == memory_space_pkg::KIND_PUSH;
   endsequence
   sequence seqCodeReserved;
      take && reqKind == memory_space_pkg::KIND_CODE && !progInRange;
   endsequence
   chk_stack_reset_value: assert property ($rose(rstN) |-> stackPtr_r == 8'h07)
      else $error("stack pointer not 0x07 after reset");
   chk_push_slot: assert property (seqPushTaken |-> ramWe && byteAddr == stackPtr_r + 8'h01)
      else $error("push not written above the stack pointer");
   chk_push_increment: assert property (seqPushTaken |=> stackPtr_r == $past(stackPtr_r) + 8'h01)
      else $error("push did not increment the stack pointer");
   chk_direct_high_sfr: assert property (take && reqKind == memory_space_pkg::KIND_DIRECT && reqAddr[7]
      && extSfr |-> sfrSel && !ramWe)
      else $error("high direct access did not reach the SFR port");
   chk_low_direct_ram: assert property (take && reqKind == memory_space_pkg::KIND_DIRECT && !reqAddr[7]
      |-> !sfrSel && byteAddr == reqAddr[7:0])
      else $error("low direct access left the RAM");
   chk_indirect_ram: assert property (take && reqKind == memory_space_pkg::KIND_INDIRECT
      |-> !sfrSel && byteAddr == ptrData)
      else $error("indirect access did not use the pointer into RAM");
   chk_bank_register: assert property (take && reqKind == memory_space_pkg::KIND_REGISTER
      |-> byteAddr == {3'b000, statusWord_r[4:3], reqAddr[2:0]} && byteAddr < 8'h20)
      else $error("register access outside the active bank");
   chk_bit_low_byte: assert property (take && isBit && !reqAddr[7]
      |-> byteAddr == 8'h20 + {4'h0, reqAddr[6:3]})
      else $error("low bit address mapped to the wrong byte");
   chk_bit_sfr_row: assert property (take && isBit && reqAddr[7]
      |-> byteAddr[2:0] == 3'b000 && byteAddr[7:3] == reqAddr[7:3])
      else $error("high bit address mapped to the wrong SFR row");
   chk_prog_read_only: assert property (take && !storeWe_r |-> !progWe)
      else $error("program memory written without write enable");
   chk_code_reserved: assert property (seqCodeReserved |=> rspValid && rspData == 8'hff)
      else $error("reserved program address did not read as 0xff");
   chk_ext_bit_wrback: assert property (needWb |=> !ready && sfrSel && sfrWrite ##1 rspValid && ready)
      else $error("SFR bit write did not complete in two cycles");

endmodule

// [src/memory_space_defines.svh]
// Address map constants for the memory space decoder.
`ifndef MEMORY_SPACE_DEFINES_SVH
`define MEMORY_SPACE_DEFINES_SVH

`define STACK_PTR_ADDR     8'h81
`define STORE_CTL_ADDR     8'h8f
`define STATUS_WORD_ADDR   8'hd0
`define STACK_PTR_RESET    8'h07
`define STATUS_WORD_RESET  8'h00
`define STORE_CTL_RESET    1'b0
`define BANK_LO_POS        3
`define BANK_HI_POS        4
`define STORE_WE_POS       0
`define BIT_BYTE_BASE      8'h20
`define FLASH_BYTES_LARGE  8192
`define FLASH_BYTES_MID    4096
`define FLASH_BYTES_SMALL  2048
`define FLASH_RESV_START   17'h01e00
`define RESERVED_READ      8'hff

`endif

// [src/memory_space_pkg.sv]
// Types shared by the memory space decoder files.
package memory_space_pkg;

   typedef enum logic [2:0] {
      KIND_DIRECT   = 3'h0,
      KIND_INDIRECT = 3'h1,
      KIND_REGISTER = 3'h2,
      KIND_BIT      = 3'h3,
      KIND_PUSH     = 3'h4,
      KIND_POP      = 3'h5,
      KIND_CODE     = 3'h6,
      KIND_XMOVE    = 3'h7
   } access_kind_type;

   typedef enum logic [0:0] {
      ST_IDLE   = 1'b0,
      ST_WRBACK = 1'b1
   } decode_state_type;

endpackage

// [src/program_store.sv]
// On-chip program memory array of selectable size.
`timescale 1ns/1ps
module program_store #(
   parameter int DEPTH = 8192
) (
   input  wire logic                     clk_sys,
   input  wire logic                     writeEn,
   input  wire logic [$clog2(DEPTH)-1:0] addr,
   input  wire logic [7:0]               writeData,
   output logic      [7:0]               readData
);
   logic [7:0] mem [0:DEPTH-1];

   assign readData = mem[addr];

   // Erase and sector timing live in the flash controller; this is only the array.
   always_ff @(posedge clk_sys) begin
      if (writeEn) begin
         mem[addr] <= writeData;
      end
   end
endmodule

// [tb/memory_space_decoder_tb.sv]
// Self-checking testbench for the memory space decoder.
`timescale 1ns/1ps
module memory_space_decoder_tb;
   localparam memory_space_pkg::access_kind_type KDIR = memory_space_pkg::KIND_DIRECT;
   localparam memory_space_pkg::access_kind_type KIND = memory_space_pkg::KIND_INDIRECT;
   localparam memory_space_pkg::access_kind_type KREG = memory_space_pkg::KIND_REGISTER;
   localparam memory_space_pkg::access_kind_type KBIT = memory_space_pkg::KIND_BIT;
   localparam memory_space_pkg::access_kind_type KPSH = memory_space_pkg::KIND_PUSH;
   localparam memory_space_pkg::access_kind_type KPOP = memory_space_pkg::KIND_POP;
   localparam memory_space_pkg::access_kind_type KCOD = memory_space_pkg::KIND_CODE;
   localparam memory_space_pkg::access_kind_type KXMV = memory_space_pkg::KIND_XMOVE;

   logic                              clk_sys = 1'b0;
   logic                              nrst = 1'b0;
   logic                              reqValid = 1'b0;
   memory_space_pkg::access_kind_type reqKind = memory_space_pkg::KIND_DIRECT;
   logic [15:0]                       reqAddr = 16'h0000;
   logic                              reqWrite = 1'b0;
   logic [7:0]                        reqWdata = 8'h00;
   logic                              reqBitData = 1'b0;
   logic                              ready, rspValid, rspBit, sfrSel, sfrWrite, program_store_write_enable;
   logic [7:0]                        rspData, sfrAddr, sfrWdata, sfrRdata, stack_top_pointer;
   logic [1:0]                        bankSelect;
   logic                              sawBusy = 1'b0;
   int                                err_total = 0;
   int                                samples_checked = 0;
   int                                sfrHits = 0;
   int                                h;

   memory_space_decoder i_dut (.clk_sys, .nrst, .reqValid, .reqKind, .reqAddr, .reqWrite, .reqWdata,
      .reqBitData, .ready, .rspValid, .rspData, .rspBit, .sfrSel, .sfrWrite, .sfrAddr, .sfrWdata,
      .sfrRdata, .stack_top_pointer, .bankSelect, .program_store_write_enable);
   sfr_bank_model i_sfr (.clk_sys, .sfrSel, .sfrWrite, .sfrAddr, .sfrWdata, .sfrRdata);

   always #50 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (sfrSel === 1'b1) sfrHits++;

   // ****************************************************
   // Bus tasks
   // ****************************************************
   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic chk1(input string what, input logic exp, input logic got);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s: expected %b, seen %b", what, exp, got);
      end
   endtask

   // Called just after an edge; returns one edge after the answer pulse is seen.
   task automatic acc(input memory_space_pkg::access_kind_type k, input logic [15:0] a, input logic w,
                      input logic [7:0] d, input logic b);
      int n;
      n = 0;
      reqValid = 1'b1;
      reqKind = k;
      reqAddr = a;
      reqWrite = w;
      reqWdata = d;
      reqBitData = b;
      sawBusy = 1'b0;
      @(posedge clk_sys);
      #1;
      reqValid = 1'b0;
      while (rspValid !== 1'b1 && n < 8) begin
         if (ready === 1'b0) sawBusy = 1'b1;
         @(posedge clk_sys);
         #1;
         n++;
      end
      chk1("answer", 1'b1, rspValid);
      // One idle edge keeps the next call from raising reqValid in the step that lowered it.
      @(posedge clk_sys);
      #1;
   endtask

   task automatic rd(input memory_space_pkg::access_kind_type k, input logic [15:0] a);
      acc(k, a, 1'b0, 8'h00, 1'b0);
   endtask

   task automatic wr(input memory_space_pkg::access_kind_type k, input logic [15:0] a, input logic [7:0] d);
      acc(k, a, 1'b1, d, 1'b0);
   endtask

   task automatic print_verdict();
      $display("checks %0d, errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      #(5000 * 100);
      err_total++;
      print_verdict();
   end

   // ****************************************************
   // Tests
   // ****************************************************
   initial begin
      repeat (20) @(posedge clk_sys);
      #1 nrst = 1'b1;
      repeat (3) @(posedge clk_sys);
      #1;
      chk8("stack ptr", 8'h07, stack_top_pointer);
      chk8("bank", 8'h00, {6'h00, bankSelect});
      chk1("store we", 1'b0, program_store_write_enable);
      // Only occupied SFR addresses are touched below.
      wr(KDIR, 16'h0030, 8'h3c);
      wr(KREG, 16'h0000, 8'hc4);
      wr(KIND, 16'h0000, 8'ha5);
      rd(KIND, 16'h0000);
      chk8("upper ram", 8'ha5, rspData);
      h = sfrHits;
      rd(KDIR, 16'h00c4);
      chk8("sfr", 8'hc4 ^ 8'h5a, rspData);
      chk8("sfr strobes", 8'h01, 8'(sfrHits - h));
      wr(KREG, 16'h0001, 8'h30);
      rd(KIND, 16'h0001);
      chk8("lower ram", 8'h3c, rspData);
      rd(KDIR, 16'h0000);
      chk8("bank reg", 8'hc4, rspData);
      for (int b = 0; b < 4; b++) begin
         wr(KDIR, 16'h00d0, 8'(b << 3));
         chk8("bank", 8'(b), {6'h00, bankSelect});
         wr(KREG, 16'h0007, 8'(8'h70 + b));
         rd(KDIR, 16'(8 * b + 7));
         chk8("bank reg", 8'(8'h70 + b), rspData);
      end
      wr(KDIR, 16'h00d0, 8'h00);
      acc(KBIT, 16'h00d4, 1'b1, 8'h00, 1'b1);
      chk8("bank", 8'h02, {6'h00, bankSelect});
      wr(KDIR, 16'h00d0, 8'h00);
      wr(KDIR, 16'h0022, 8'h00);
      acc(KBIT, 16'h0013, 1'b1, 8'h00, 1'b1);
      rd(KDIR, 16'h0022);
      chk8("bit byte", 8'h08, rspData);
      wr(KDIR, 16'h002f, 8'h80);
      rd(KBIT, 16'h007f);
      chk1("bit", 1'b1, rspBit);
      rd(KBIT, 16'h0017);
      chk1("bit", 1'b0, rspBit);
      rd(KDIR, 16'h0017);
      chk8("byte", 8'h72, rspData);
      acc(KBIT, 16'h0085, 1'b1, 8'h00, 1'b1);
      chk1("busy", 1'b1, sawBusy);
      rd(KDIR, 16'h0080);
      chk8("sfr bit", (8'h80 ^ 8'h5a) | 8'h20, rspData);
      acc(KBIT, 16'h008d, 1'b1, 8'h00, 1'b1);
      rd(KDIR, 16'h0088);
      chk8("sfr bit", (8'h88 ^ 8'h5a) | 8'h20, rspData);
      rd(KDIR, 16'h008d);
      chk8("sfr byte", 8'h8d ^ 8'h5a, rspData);
      wr(KDIR, 16'h0090, 8'h55);
      chk1("busy", 1'b0, sawBusy);
      rd(KDIR, 16'h0090);
      chk8("sfr write", 8'h55, rspData);
      acc(KPSH, 16'h0000, 1'b1, 8'h11, 1'b0);
      chk8("stack ptr", 8'h08, stack_top_pointer);
      rd(KDIR, 16'h0008);
      chk8("stack", 8'h11, rspData);
      rd(KPOP, 16'h0000);
      chk8("pop", 8'h11, rspData);
      chk8("stack ptr", 8'h07, stack_top_pointer);
      h = sfrHits;
      wr(KDIR, 16'h0081, 8'hff);
      chk8("sfr strobes", 8'h00, 8'(sfrHits - h));
      acc(KPSH, 16'h0000, 1'b1, 8'h99, 1'b0);
      chk8("stack ptr", 8'h00, stack_top_pointer);
      rd(KDIR, 16'h0000);
      chk8("stack", 8'h99, rspData);
      rd(KDIR, 16'h0081);
      chk8("stack ptr", 8'h00, rspData);
      wr(KDIR, 16'h008f, 8'h01);
      chk1("store we", 1'b1, program_store_write_enable);
      wr(KXMV, 16'h1dff, 8'h6b);
      wr(KXMV, 16'h0030, 8'he7);
      rd(KCOD, 16'h1dff);
      chk8("code", 8'h6b, rspData);
      rd(KCOD, 16'h0030);
      chk8("code", 8'he7, rspData);
      rd(KDIR, 16'h0030);
      chk8("data", 8'h3c, rspData);
      wr(KDIR, 16'h008f, 8'h00);
      chk1("store we", 1'b0, program_store_write_enable);
      wr(KXMV, 16'h1dff, 8'h00);
      rd(KCOD, 16'h1dff);
      chk8("code", 8'h6b, rspData);
      rd(KCOD, 16'h1e00);
      chk8("code", 8'hff, rspData);
      rd(KCOD, 16'hffff);
      chk8("code", 8'hff, rspData);
      rd(KXMV, 16'h1dff);
      chk8("xmove", 8'hff, rspData);
      // A second reset mid-run must bring back the pointer, bank and write enable.
      wr(KDIR, 16'h00d0, 8'h18);
      wr(KDIR, 16'h008f, 8'h01);
      nrst = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1 nrst = 1'b1;
      repeat (3) @(posedge clk_sys);
      #1;
      chk8("stack ptr", 8'h07, stack_top_pointer);
      chk8("bank", 8'h00, {6'h00, bankSelect});
      chk1("store we", 1'b0, program_store_write_enable);
      acc(KPSH, 16'h0000, 1'b1, 8'h5e, 1'b0);
      rd(KDIR, 16'h0008);
      chk8("stack", 8'h5e, rspData);
      print_verdict();
   end
endmodule

// [tb/sfr_bank_model.sv]
// External special function register bank answering the decoder's SFR strobe.
`timescale 1ns/1ps
module sfr_bank_model (
   input  wire logic       clk_sys,
   input  wire logic       sfrSel,
   input  wire logic       sfrWrite,
   input  wire logic [7:0] sfrAddr,
   input  wire logic [7:0] sfrWdata,
   output logic      [7:0] sfrRdata
);
   logic [7:0] regs [0:255];
   logic [7:0] idleVal;

   initial begin
      idleVal = 8'h3c;
      for (int i = 0; i < 256; i++) regs[i] = 8'(i) ^ 8'h5a;
   end

   always @(posedge clk_sys) begin
      idleVal <= ~idleVal;
      if (sfrSel && sfrWrite) regs[sfrAddr] <= sfrWdata;
   end

   // Unselected, the bus flips every cycle, so a stale byte can never pass for an answer.
   assign sfrRdata = sfrSel ? regs[sfrAddr] : idleVal;
endmodule
